// *** common/scs_defs.svh ***
// constants of the sensor control two-wire slave
`ifndef SCS_DEFS_SVH
`define SCS_DEFS_SVH

// write-form bus addresses for strap values 00, 01, 10, 11
`define SCS_ADDR_SEL0      8'h90
`define SCS_ADDR_SEL1      8'h98
`define SCS_ADDR_SEL2      8'hb0
`define SCS_ADDR_SEL3      8'hb8

// direction bit position inside the address byte (1 = read)
`define SCS_DIR_BIT        0

// special registers for byte-wise access
`define SCS_SPECIAL_WR_LOW 8'hf0
`define SCS_SPECIAL_RD_LOW 8'hf1

// bit counts of one byte
`define SCS_BITS_PER_BYTE  4'h8
`define SCS_LAST_TX_BIT    4'h7

// reset values
`define SCS_REG_RESET      16'h0000
`define SCS_ADDR_RESET     8'h00
`define SCS_BYTE_RESET     8'h00

// register file depth
`define SCS_REG_DEPTH      256

`endif

// *** common/scs_pkg.sv ***
// types and helper functions of the sensor control two-wire slave
`default_nettype none
`include "scs_defs.svh"

package scs_pkg;

  typedef logic [7:0]  scs_byte_t;
  typedef logic [15:0] scs_word_t;

  // protocol sequencer states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_REG,
    ST_REG_ACK,
    ST_WR,
    ST_WR_ACK,
    ST_RD,
    ST_RD_ACK,
    ST_IGNORE
  } scs_state_t;

  // write-form bus address chosen by the two strap pins
  function automatic scs_byte_t scs_slave_addr(input logic [1:0] sel);
    case (sel)
      2'h0:    scs_slave_addr = `SCS_ADDR_SEL0;
      2'h1:    scs_slave_addr = `SCS_ADDR_SEL1;
      2'h2:    scs_slave_addr = `SCS_ADDR_SEL2;
      default: scs_slave_addr = `SCS_ADDR_SEL3;
    endcase
  endfunction

  // register address after one 16-bit word, wraps at the top
  function automatic scs_byte_t scs_next_addr(input scs_byte_t a);
    scs_next_addr = a + 8'h01;
  endfunction

endpackage
`default_nettype wire

// *** logic/scs_i2c_slave.sv ***
// two-wire serial control slave giving a bus master access to 16-bit registers
`timescale 1ns/1ps
`default_nettype none
`include "scs_defs.svh"
module scs_i2c_slave (
  input  wire logic               sys_clk,             // system clock, 40 MHz
  input  wire logic               rst_b,               // async reset, active low
  input  wire logic               serialClockLine,     // bus clock from master
  input  wire logic               serialDataLineIn,    // level of the data line
  output logic                    serialDataLineOut,   // value driven, always low
  output logic                    serialDataLineOe,    // high while pulling low
  input  wire logic               addrSelectLowPin,    // address strap, low bit
  input  wire logic               addrSelectHighPin,   // address strap, high bit
  output logic                    regWrStrobe,         // one-cycle register commit
  output scs_pkg::scs_byte_t      regWrAddr,           // committed register
  output scs_pkg::scs_word_t      regWrData,           // committed value
  output logic                    busActive            // between start and stop
);
  import scs_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  // declarations
  logic       sclMeta_ff;
  logic       sclSync_ff;
  logic       sclPrev_ff;
  logic       sdaMeta_ff;
  logic       sdaSync_ff;
  logic       sdaPrev_ff;
  logic [1:0] selMeta_ff;
  logic [1:0] selSync_ff;
  scs_state_t state_ff;
  scs_state_t nxt_state;
  logic [3:0] bitCnt_ff;
  logic [3:0] nxt_bitCnt;
  scs_byte_t  shift_ff;
  scs_byte_t  nxt_shift;
  logic       readMode_ff;
  logic       nxt_readMode;
  scs_byte_t  regAddr_ff;
  scs_byte_t  nxt_regAddr;
  logic       bytePhase_ff;
  logic       nxt_bytePhase;
  scs_byte_t  heldHi_ff;
  scs_byte_t  nxt_heldHi;
  scs_byte_t  heldTarget_ff;
  scs_byte_t  nxt_heldTarget;
  scs_byte_t  heldLow_ff;
  scs_byte_t  nxt_heldLow;
  logic       masterAck_ff;
  logic       nxt_masterAck;
  logic       sdaOe_ff;
  logic       nxt_sdaOe;
  logic       wrEn_ff;
  logic       nxt_wrEn;
  scs_byte_t  wrAddr_ff;
  scs_byte_t  nxt_wrAddr;
  scs_word_t  wrData_ff;
  scs_word_t  nxt_wrData;
  scs_word_t  rdData;

  ////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers, then one delay stage for edge detection
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclMeta_ff <= 1'b1;
      sclSync_ff <= 1'b1;
      sclPrev_ff <= 1'b1;
      sdaMeta_ff <= 1'b1;
      sdaSync_ff <= 1'b1;
      sdaPrev_ff <= 1'b1;
      selMeta_ff <= 2'h0;
      selSync_ff <= 2'h0;
    end else begin
      sclMeta_ff <= serialClockLine;
      sclSync_ff <= sclMeta_ff;
      sclPrev_ff <= sclSync_ff;
      sdaMeta_ff <= serialDataLineIn;
      sdaSync_ff <= sdaMeta_ff;
      sdaPrev_ff <= sdaSync_ff;
      selMeta_ff <= {addrSelectHighPin, addrSelectLowPin};
      selSync_ff <= selMeta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // line events
  wire sclRise   = sclSync_ff & ~sclPrev_ff;
  wire sclFall   = ~sclSync_ff & sclPrev_ff;
  wire startSeen = sclSync_ff & sclPrev_ff & sdaPrev_ff & ~sdaSync_ff;
  wire stopSeen  = sclSync_ff & sclPrev_ff & ~sdaPrev_ff & sdaSync_ff;
  wire byteDone  = sclFall & (bitCnt_ff == `SCS_BITS_PER_BYTE);
  wire txLast    = bitCnt_ff == `SCS_LAST_TX_BIT;
  ////////////////////////////////////////////////////////////////////////
  // address compare on the seven upper bits
  wire scs_byte_t ownAddr = scs_slave_addr(selSync_ff);
  wire addrHit  = shift_ff[7:1] == ownAddr[7:1];
  wire dirRead  = shift_ff[`SCS_DIR_BIT];

  ////////////////////////////////////////////////////////////////////////
  // byte to send next: upper byte, lower byte, or held lower byte via 0xF1
  wire isRdLowReg = regAddr_ff == `SCS_SPECIAL_RD_LOW;
  wire isWrLowReg = regAddr_ff == `SCS_SPECIAL_WR_LOW;
  wire scs_byte_t txByte = bytePhase_ff ? rdData[7:0] :
                           (isRdLowReg ? heldLow_ff : rdData[15:8]);

  ////////////////////////////////////////////////////////////////////////
  // protocol sequencer
  always_comb begin
    nxt_state      = state_ff;
    nxt_bitCnt     = bitCnt_ff;
    nxt_shift      = shift_ff;
    nxt_readMode   = readMode_ff;
    nxt_regAddr    = regAddr_ff;
    nxt_bytePhase  = bytePhase_ff;
    nxt_heldHi     = heldHi_ff;
    nxt_heldTarget = heldTarget_ff;
    nxt_heldLow    = heldLow_ff;
    nxt_masterAck  = masterAck_ff;
    nxt_sdaOe      = sdaOe_ff;
    nxt_wrEn       = 1'b0;
    nxt_wrAddr     = wrAddr_ff;
    nxt_wrData     = wrData_ff;
    if (startSeen) begin
      // start or repeated start always restarts address reception
      nxt_state  = ST_ADDR;
      nxt_bitCnt = 4'h0;
      nxt_sdaOe  = 1'b0;
    end else if (stopSeen) begin
      nxt_state  = ST_IDLE;
      nxt_sdaOe  = 1'b0;
    end else begin
      case (state_ff)
        ST_ADDR, ST_REG, ST_WR: begin
          if (sclRise && bitCnt_ff != `SCS_BITS_PER_BYTE) begin
            nxt_shift  = {shift_ff[6:0], sdaSync_ff};
            nxt_bitCnt = bitCnt_ff + 4'h1;
          end else if (byteDone) begin
            nxt_bitCnt = 4'h0;
            nxt_sdaOe  = 1'b1;
            if (state_ff == ST_ADDR) begin
              if (addrHit) begin
                nxt_state    = ST_ADDR_ACK;
                nxt_readMode = dirRead;
                if (dirRead) begin
                  nxt_bytePhase = 1'b0;
                end
              end else begin
                nxt_state = ST_IGNORE;
                nxt_sdaOe = 1'b0;
              end
            end else if (state_ff == ST_REG) begin
              nxt_state     = ST_REG_ACK;
              nxt_regAddr   = shift_ff;
              nxt_bytePhase = 1'b0;
            end else begin
              nxt_state = ST_WR_ACK;
              if (bytePhase_ff) begin
                // lower byte completes the word
                nxt_wrEn      = 1'b1;
                nxt_wrAddr    = regAddr_ff;
                nxt_wrData    = {heldHi_ff, shift_ff};
                nxt_regAddr   = scs_next_addr(regAddr_ff);
                nxt_bytePhase = 1'b0;
              end else if (isWrLowReg) begin
                // lower byte for the register whose upper byte is held
                nxt_wrEn   = 1'b1;
                nxt_wrAddr = heldTarget_ff;
                nxt_wrData = {heldHi_ff, shift_ff};
              end else begin
                nxt_heldHi     = shift_ff;
                nxt_heldTarget = regAddr_ff;
                nxt_bytePhase  = 1'b1;
              end
            end
          end
        end
        ST_ADDR_ACK: begin
          if (sclFall) begin
            if (readMode_ff) begin
              nxt_state  = ST_RD;
              nxt_shift  = txByte;
              nxt_sdaOe  = ~txByte[7];
              nxt_bitCnt = 4'h0;
              nxt_heldLow   = isRdLowReg ? heldLow_ff : rdData[7:0];
              nxt_bytePhase = 1'b1;
            end else begin
              nxt_state = ST_REG;
              nxt_sdaOe = 1'b0;
            end
          end
        end
        ST_REG_ACK, ST_WR_ACK: begin
          if (sclFall) begin
            nxt_state = ST_WR;
            nxt_sdaOe = 1'b0;
          end
        end
        ST_RD: begin
          if (sclFall) begin
            if (txLast) begin
              nxt_state  = ST_RD_ACK;
              nxt_sdaOe  = 1'b0;
              nxt_bitCnt = 4'h0;
            end else begin
              nxt_shift  = {shift_ff[6:0], 1'b0};
              nxt_sdaOe  = ~shift_ff[6];
              nxt_bitCnt = bitCnt_ff + 4'h1;
            end
          end
        end
        ST_RD_ACK: begin
          if (sclRise) begin
            nxt_masterAck = ~sdaSync_ff;
          end else if (sclFall) begin
            if (masterAck_ff) begin
              nxt_state  = ST_RD;
              nxt_shift  = txByte;
              nxt_sdaOe  = ~txByte[7];
              nxt_bitCnt = 4'h0;
              if (bytePhase_ff) begin
                nxt_regAddr   = scs_next_addr(regAddr_ff);
                nxt_bytePhase = 1'b0;
              end else begin
                nxt_heldLow   = isRdLowReg ? heldLow_ff : rdData[7:0];
                nxt_bytePhase = 1'b1;
              end
            end else begin
              nxt_state = ST_IGNORE;
              nxt_sdaOe = 1'b0;
            end
          end
        end
        ST_IDLE, ST_IGNORE: begin
          nxt_sdaOe = 1'b0;
        end
        default: begin
          nxt_state = ST_IDLE;
          nxt_sdaOe = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer and bit registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff     <= ST_IDLE;
      bitCnt_ff    <= 4'h0;
      shift_ff     <= `SCS_BYTE_RESET;
      readMode_ff  <= 1'b0;
      masterAck_ff <= 1'b0;
      sdaOe_ff     <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      bitCnt_ff    <= nxt_bitCnt;
      shift_ff     <= nxt_shift;
      readMode_ff  <= nxt_readMode;
      masterAck_ff <= nxt_masterAck;
      sdaOe_ff     <= nxt_sdaOe;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // address and byte-pairing registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      regAddr_ff    <= `SCS_ADDR_RESET;
      bytePhase_ff  <= 1'b0;
      heldHi_ff     <= `SCS_BYTE_RESET;
      heldTarget_ff <= `SCS_ADDR_RESET;
      heldLow_ff    <= `SCS_BYTE_RESET;
    end else begin
      regAddr_ff    <= nxt_regAddr;
      bytePhase_ff  <= nxt_bytePhase;
      heldHi_ff     <= nxt_heldHi;
      heldTarget_ff <= nxt_heldTarget;
      heldLow_ff    <= nxt_heldLow;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // commit registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrEn_ff   <= 1'b0;
      wrAddr_ff <= `SCS_ADDR_RESET;
      wrData_ff <= `SCS_REG_RESET;
    end else begin
      wrEn_ff   <= nxt_wrEn;
      wrAddr_ff <= nxt_wrAddr;
      wrData_ff <= nxt_wrData;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register file, read address follows the current register pointer
  scs_reg_mem u_regMem (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .wrEn      (wrEn_ff),
    .wrAddr    (wrAddr_ff),
    .wrData    (wrData_ff),
    .rdAddr    (regAddr_ff),
    .rdData_ff (rdData)
  );

  ////////////////////////////////////////////////////////////////////////
  // outputs: the line is only ever pulled low
  assign serialDataLineOut = 1'b0;
  assign serialDataLineOe  = sdaOe_ff;
  assign regWrStrobe       = wrEn_ff;
  assign regWrAddr         = wrAddr_ff;
  assign regWrData         = wrData_ff;
  assign busActive         = (state_ff != ST_IDLE);
endmodule
`default_nettype wire

// *** logic/scs_reg_mem.sv ***
// sixteen-bit register file with one write port and a registered read port
`timescale 1ns/1ps
`default_nettype none
`include "scs_defs.svh"

module scs_reg_mem (
  input  wire logic              sys_clk,  // system clock
  input  wire logic              rst_b,    // async reset, active low
  input  wire logic              wrEn,     // write strobe
  input  wire scs_pkg::scs_byte_t wrAddr,  // write address
  input  wire scs_pkg::scs_word_t wrData,  // write data
  input  wire scs_pkg::scs_byte_t rdAddr,  // read address
  output var  scs_pkg::scs_word_t rdData_ff // read data, one cycle late
);
  import scs_pkg::*;

  scs_word_t memArray_ff [`SCS_REG_DEPTH];

  ////////////////////////////////////////////////////////////////////////
  // storage, cleared at reset so reads never return unknown data
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < `SCS_REG_DEPTH; i++) begin
        memArray_ff[i] <= `SCS_REG_RESET;
      end
    end else if (wrEn) begin
      memArray_ff[wrAddr] <= wrData;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered read
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData_ff <= `SCS_REG_RESET;
    end else begin
      rdData_ff <= memArray_ff[rdAddr];
    end
  end

endmodule
`default_nettype wire

// *** sim/scs_bus_master.sv ***
// bus master model driving the two-wire link
`timescale 1ns/1ps
`default_nettype none
module scs_bus_master (
  output var logic serialClockLine, // bus clock, idles high
  output var logic pullLow,         // high while pulling data low
  input wire logic dataWire         // resolved data wire
);
  // idle: both lines high
  initial begin
    serialClockLine = 1'b1;
    pullLow = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one clock pulse: data set while low, sampled mid-high
  task automatic bitCycle(input logic b, output logic r);
    #25 pullLow = ~b;
    #125 serialClockLine = 1'b1;
    #25 r = dataWire;
    #25 serialClockLine = 1'b0;
  endtask
  // start, also repeated start from clock low
  task automatic start();
    #25 pullLow = 1'b0;
    #125 serialClockLine = 1'b1;
    #100 pullLow = 1'b1;
    #100 serialClockLine = 1'b0;
  endtask
  // stop leaves the bus idle
  task automatic stop();
    #25 pullLow = 1'b1;
    #125 serialClockLine = 1'b1;
    #100 pullLow = 1'b0;
    #100;
  endtask
  // byte out, then released for the answer
  task automatic wrByte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitCycle(d[i], r);
    bitCycle(1'b1, r);
    ack = ~r;
  endtask
  // byte in, then ack or nack
  task automatic rdByte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitCycle(1'b1, d[i]);
    bitCycle(~ack, r);
  endtask
endmodule
`default_nettype wire

// *** sim/scs_i2c_slave_monitor.sv ***
// assertion checker of the two-wire control slave ports
`timescale 1ns/1ps
`default_nettype none
module scs_i2c_slave_monitor (
  input wire logic               sys_clk,           // system clock
  input wire logic               rst_b,             // reset, active low
  input wire logic               serialClockLine,   // bus clock
  input wire logic               serialDataLineIn,  // data wire level
  input wire logic               serialDataLineOut, // driven value
  input wire logic               serialDataLineOe,  // pull-low enable
  input wire logic               addrSelectLowPin,  // strap low
  input wire logic               addrSelectHighPin, // strap high
  input wire logic               regWrStrobe,       // commit pulse
  input wire scs_pkg::scs_byte_t regWrAddr,         // commit index
  input wire scs_pkg::scs_word_t regWrData,         // commit value
  input wire logic               busActive          // transaction open
);
  import scs_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////////
  // line driving: only low, only inside a transaction, enable changing only while clock low
  property p_out_low; serialDataLineOut == 1'b0; endproperty
  a_out_low: assert property (p_out_low) else $error("data driven high");
  property p_idle_release; !busActive |-> !serialDataLineOe; endproperty
  a_idle_release: assert property (p_idle_release) else $error("line pulled while idle");
  property p_change_low; $changed(serialDataLineOe) |-> !serialClockLine; endproperty
  a_change_low: assert property (p_change_low) else $error("data changed with clock high");
  // start and stop framing
  property p_start; serialClockLine && $past(serialClockLine) && $fell(serialDataLineIn) |-> ##[1:6] busActive;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_stop; serialClockLine && $past(serialClockLine) && $rose(serialDataLineIn) |-> ##[1:6] !busActive;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not taken");
  // register commits: whole words, acknowledged, one-cycle pulse
  property p_commit; regWrStrobe |-> busActive ##1 !regWrStrobe; endproperty
  a_commit: assert property (p_commit) else $error("commit pulse wrong");
  property p_commit_ack; regWrStrobe |-> ##[0:2] serialDataLineOe; endproperty
  a_commit_ack: assert property (p_commit_ack) else $error("commit without ack");
  property p_hold; $changed(regWrAddr) || $changed(regWrData) |-> regWrStrobe; endproperty
  a_hold: assert property (p_hold) else $error("commit value moved alone");
  property p_reset_quiet; $rose(rst_b) |-> !busActive && !serialDataLineOe && !regWrStrobe && regWrData == 16'h0000;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
endmodule

bind scs_i2c_slave scs_i2c_slave_monitor u_mon (.sys_clk(sys_clk), .rst_b(rst_b),
  .serialClockLine(serialClockLine), .serialDataLineIn(serialDataLineIn), .serialDataLineOut(serialDataLineOut),
  .serialDataLineOe(serialDataLineOe), .addrSelectLowPin(addrSelectLowPin), .addrSelectHighPin(addrSelectHighPin),
  .regWrStrobe(regWrStrobe), .regWrAddr(regWrAddr), .regWrData(regWrData), .busActive(busActive));
`default_nettype wire

// *** sim/scs_i2c_slave_tb.sv ***
// self-checking bench of the two-wire control slave
`timescale 1ns/1ps
`default_nettype none
module scs_i2c_slave_tb;
  import scs_pkg::*;
  logic            sys_clk, rst_b, selLow, selHigh, ack;
  wire logic       sclLine, mPull, dOut, dOe, wrStb, active;
  wire scs_byte_t  wrAddr;
  wire scs_word_t  wrData;
  scs_byte_t       rd;
  int              bad_count = 0, checks_done = 0, cycles = 0;
  logic [23:0]     commits[$];
  // open-drain wire with pull-up
  wire logic sdaWire = (dOe ? dOut : 1'b1) & ~mPull;

  scs_i2c_slave uut (.sys_clk(sys_clk), .rst_b(rst_b), .serialClockLine(sclLine), .serialDataLineIn(sdaWire),
    .serialDataLineOut(dOut), .serialDataLineOe(dOe), .addrSelectLowPin(selLow), .addrSelectHighPin(selHigh),
    .regWrStrobe(wrStb), .regWrAddr(wrAddr), .regWrData(wrData), .busActive(active));
  scs_bus_master master (.serialClockLine(sclLine), .pullLow(mPull), .dataWire(sdaWire));

  // clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // commit capture and hang limit
  always @(posedge sys_clk) begin
    cycles++;
    if (wrStb === 1'b1) commits.push_back({wrAddr, wrData});
    if (cycles == 20000) begin
      bad_count++;
      $display("CHECK FAILED at %0t: timeout", $time);
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #3;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic takeCommit(input logic [23:0] exp);
    logic [23:0] got;
    got = (commits.size() > 0) ? commits.pop_front() : 24'hxxxxxx;
    check(got, exp, "commit");
  endtask
  task automatic open(input scs_byte_t id);
    master.start();
    master.wrByte(id, ack);
    check(ack, 1'b1, "address ack");
    check(active, 1'b1, "bus busy");
  endtask
  task automatic setPtr(input scs_byte_t r);
    open(8'h90);
    master.wrByte(r, ack);
    check(ack, 1'b1, "register ack");
  endtask
  task automatic finishStop();
    master.stop();
    tick(8);
    check(active, 1'b0, "bus idle");
    check(sdaWire, 1'b1, "line released");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic testReset();
    check({dOe, dOut, wrStb, active, wrAddr, wrData}, 0, "reset outputs");
    $display("test reset done");
  endtask
  task automatic testWrite();
    scs_byte_t wd[5] = '{8'h02, 8'h84, 8'h12, 8'h34, 8'h55};
    setPtr(8'h09);
    foreach (wd[i]) begin
      master.wrByte(wd[i], ack);
      check(ack, 1'b1, "data ack");
    end
    finishStop();
    takeCommit({8'h09, 16'h0284});
    takeCommit({8'h0a, 16'h1234});
    check(commits.size(), 0, "extra commit");
    $display("test write done");
  endtask
  task automatic testRead();
    scs_byte_t ex[4] = '{8'h02, 8'h84, 8'h12, 8'h34};
    setPtr(8'h09);
    open(8'h91);
    foreach (ex[i]) begin
      master.rdByte(i < 3, rd);
      check(rd, ex[i], "read data");
    end
    tick(16);
    check(dOe, 1'b0, "released after nack");
    finishStop();
    $display("test read done");
  endtask
  task automatic testSelect();
    scs_byte_t ids[4] = '{8'h90, 8'h98, 8'hb0, 8'hb8};
    for (int s = 0; s < 4; s++) begin
      {selHigh, selLow} = 2'(s);
      tick(4);
      for (int a = 0; a < 4; a++) begin
        master.start();
        master.wrByte(ids[a], ack);
        check(ack, a == s, "select ack");
        master.wrByte(8'h40, ack);
        check(ack, a == s, "ignored byte");
        finishStop();
      end
    end
    {selHigh, selLow} = 2'b00;
    tick(4);
    check(commits.size(), 0, "stray commit");
    $display("test select done");
  endtask
  task automatic testByteWise();
    setPtr(8'h20);
    master.wrByte(8'hab, ack);
    check(ack, 1'b1, "upper byte ack");
    finishStop();
    check(commits.size(), 0, "half commit");
    setPtr(8'hf0);
    master.wrByte(8'hcd, ack);
    check(ack, 1'b1, "low byte ack");
    finishStop();
    takeCommit({8'h20, 16'habcd});
    setPtr(8'h20);
    open(8'h91);
    master.rdByte(1'b0, rd);
    check(rd, 8'hab, "upper byte");
    finishStop();
    setPtr(8'hf1);
    open(8'h91);
    master.rdByte(1'b0, rd);
    check(rd, 8'hcd, "lower byte");
    finishStop();
    $display("test bytewise done");
  endtask
  // main sequence
  initial begin
    rst_b = 1'b0;
    selLow = 1'b0;
    selHigh = 1'b0;
    ack = 1'b0;
    tick(5);
    testReset();
    rst_b = 1'b1;
    tick(4);
    testWrite();
    testRead();
    testSelect();
    testByteWise();
    conclude();
  end
endmodule
`default_nettype wire
